// ---- core/srl_pkg.sv ----
package srl_pkg;

   // ==============================================================
   // Register map (byte addresses, one aligned word each)
   // ==============================================================
   localparam logic [7:0] SRL_OFF_CMD       = 8'h00; // Command strobes, write only
   localparam logic [7:0] SRL_OFF_ARMED     = 8'h04; // Armed request enables, read only
   localparam logic [7:0] SRL_OFF_STATUS    = 8'h08; // Live status byte, read only
   localparam logic [7:0] SRL_OFF_VALUE     = 8'h0c; // Active value output, read only
   localparam logic [7:0] SRL_OFF_IRQ_STAT  = 8'h10; // Sticky events, clear on read
   localparam logic [7:0] SRL_OFF_IRQ_MASK  = 8'h14; // Interrupt mask, read/write
   localparam logic [7:0] SRL_OFF_POLL_BYTE = 8'h18; // Byte sent at last serial poll

   // ==============================================================
   // Command register bit positions
   // ==============================================================
   localparam int SRL_CMD_MASK_CLR  = 0; // request_mask_clear_cmd
   localparam int SRL_CMD_SWEEP_EN  = 1; // sweep_end_request_enable_cmd
   localparam int SRL_CMD_FAULT_EN  = 2; // fault_request_enable_cmd
   localparam int SRL_CMD_KEY_EN    = 3; // key_request_enable_cmd
   localparam int SRL_CMD_ENTRY_EN  = 4; // keypad_entry_enable_cmd
   localparam int SRL_CMD_VALUE_OUT = 5; // active_value_output_cmd

   // ==============================================================
   // Status byte bit positions
   // ==============================================================
   localparam int SRL_STB_UNITS_KEY = 1;
   localparam int SRL_STB_SWEEP_END = 2;
   localparam int SRL_STB_HW_FAULT  = 3;
   localparam int SRL_STB_ILLEGAL   = 5;
   localparam int SRL_STB_RQS       = 6;

   // ==============================================================
   // Interrupt status / mask bit positions
   // ==============================================================
   localparam int SRL_IRQ_SRQ_RAISED = 0;
   localparam int SRL_IRQ_POLLED     = 1;
   localparam int SRL_IRQ_VALUE_OUT  = 2;
   localparam int SRL_IRQ_ENTRY_DONE = 3;
   localparam int SRL_IRQ_W          = 4;

   // ==============================================================
   // Types
   // ==============================================================
   // One bit per request source
   typedef struct packed {
      logic illegal;
      logic fault;
      logic sweep;
      logic key;
   } srl_evt_t;

   // Armed enables; illegal command needs none
   typedef struct packed {
      logic entry;
      logic key;
      logic fault;
      logic sweep;
   } srl_arm_t;

   // Reset values: reset acts as a preset, so the fault request is armed
   localparam srl_arm_t   SRL_ARM_RST      = '{entry: 1'b0, key: 1'b0, fault: 1'b1, sweep: 1'b0};
   localparam logic [3:0] SRL_IRQ_MASK_RST = 4'h0;

endpackage : srl_pkg

// ---- core/srl_service_request.sv ----
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
// Summary of operation
// RL1: Serial poll reads status byte, releases SRQ
// RL2: Sweep-end enable arms sweep completion request
// RL3: Mask clear disarms the sweep-end request
// RL4: Mask clear first, then same-write enables apply
// RL5: Controller re-sends key enable after each service
// RL6: Units key ending keypad entry raises request
// RL7: Value output command returns last keypad value
// RL8: Front-panel service key accepted only in local
// RL9: Service key raises units-key request without any enable
// RL10: Status byte bits 1,2,3,5; bit 6 RQS
// RL11: Illegal command request always asserts SRQ
// RL12: Key enable self-cancels on use or clear
// RL13: Instrument preset arms the fault request
// RL14: Coincident events all recorded; SRQ held until poll
module srl_service_request
   import srl_pkg::*;
(
   input  wire logic        pclk,            // 20 MHz bus clock
   input  wire logic        presetn,         // Async reset, active low
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        preset_req,      // Instrument preset pulse
   input  wire logic        sweep_done,      // Sweep completed pulse
   input  wire logic        hw_fault,        // Hardware broken pulse
   input  wire logic        illegal_cmd,     // Illegal command pulse
   input  wire logic [31:0] keypad_value,    // Value on the data keys
   input  wire logic        units_key_pin,   // Units key, async pin
   input  wire logic        service_key_pin, // Front-panel service combo, async pin
   input  wire logic        local_mode_pin,  // Local mode level, async pin
   input  wire logic        poll_req,        // Serial poll strobe from bus side
   output logic      [7:0]  poll_byte,       // Status byte returned by the poll
   output logic      [31:0] active_value,    // Value returned on output command
   input  wire logic        srq_i,           // SRQ wire level
   output logic             srq_o,           // SRQ drive level (always low)
   output logic             srq_oe,          // High while pulling SRQ true
   output logic             irq              // Level interrupt to local CPU
);

   // ==============================================================
   // Declarations
   // ==============================================================
   logic [3:0]  sync1_q;        // First synchroniser stage
   logic [3:0]  sync2_q;        // Second synchroniser stage
   logic        units_prev_q;   // Units key edge history
   logic        svc_prev_q;     // Service key edge history
   srl_arm_t    armed_q;        // Armed enables
   srl_arm_t    armed_d;
   srl_evt_t    pend_q;         // Pending requests
   srl_evt_t    pend_d;
   srl_evt_t    new_evt;        // Requests raised this cycle
   logic        srq_oe_q;       // Registered SRQ drive
   logic [7:0]  poll_byte_q;    // Last polled byte
   logic [31:0] value_q;        // Last keypad entry
   logic [31:0] out_value_q;    // Value presented on output command
   logic [3:0]  irq_stat_q;     // Sticky interrupt events
   logic [3:0]  irq_stat_d;
   logic [3:0]  irq_mask_q;     // Interrupt mask
   logic [3:0]  irq_evt;        // Interrupt events this cycle
   logic [7:0]  stb_w;          // Live status byte

   // Named decode wires
   wire         units_s   = sync2_q[0];
   wire         svc_s     = sync2_q[1];
   wire         local_s   = sync2_q[2];
   wire         srq_s     = sync2_q[3];
   wire         access    = psel & penable;
   wire         wr_acc    = access & pwrite;
   wire         rd_acc    = access & ~pwrite;
   wire         cmd_wr    = wr_acc & (paddr == SRL_OFF_CMD);
   wire         mask_wr   = wr_acc & (paddr == SRL_OFF_IRQ_MASK);
   wire         irq_rd    = rd_acc & (paddr == SRL_OFF_IRQ_STAT);
   wire         key_edge  = units_s & ~units_prev_q;
   wire         svc_edge  = svc_s & ~svc_prev_q;
   wire         svc_press = svc_edge & local_s;                   // RL8
   wire         entry_done = key_edge & armed_q.entry;            // RL6
   wire         key_used  = entry_done & armed_q.key;             // RL6
   wire         value_cmd = cmd_wr & pwdata[SRL_CMD_VALUE_OUT];
   wire         any_pend  = (pend_d != '0);

   // ==============================================================
   // Pin synchronisers
   // ==============================================================
   // Two flops per pin, then key edge history; only stage two is decoded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q      <= 4'h0;
         sync2_q      <= 4'h0;
         units_prev_q <= 1'b0;
         svc_prev_q   <= 1'b0;
      end else begin
         sync1_q      <= {srq_i, local_mode_pin, service_key_pin, units_key_pin};
         sync2_q      <= sync1_q;
         units_prev_q <= units_s;
         svc_prev_q   <= svc_s;
      end
   end

   // ==============================================================
   // Request sources
   // ==============================================================
   // Service key needs no enable; illegal command never needs one
   assign new_evt.key     = key_used | svc_press;               // RL9
   assign new_evt.sweep   = sweep_done & armed_q.sweep;         // RL2
   assign new_evt.fault   = hw_fault & armed_q.fault;
   assign new_evt.illegal = illegal_cmd;                        // RL11

   // ==============================================================
   // Armed enables
   // ==============================================================
   // Clear acts first so enables in the same write survive it
   always_comb begin
      armed_d = armed_q;
      if (key_used || poll_req) begin
         armed_d.key = 1'b0;                                    // RL12
      end
      if (entry_done) begin
         armed_d.entry = 1'b0;
      end
      if (cmd_wr) begin
         if (pwdata[SRL_CMD_MASK_CLR]) begin
            armed_d.sweep = 1'b0;                               // RL3
            armed_d.fault = 1'b0;
            armed_d.key   = 1'b0;                               // RL4
         end
         if (pwdata[SRL_CMD_SWEEP_EN]) begin
            armed_d.sweep = 1'b1;                               // RL2
         end
         if (pwdata[SRL_CMD_FAULT_EN]) begin
            armed_d.fault = 1'b1;
         end
         if (pwdata[SRL_CMD_KEY_EN]) begin
            armed_d.key = 1'b1;
         end
         if (pwdata[SRL_CMD_ENTRY_EN]) begin
            armed_d.entry = 1'b1;
         end
      end
      if (preset_req) begin
         armed_d.fault = 1'b1;                                  // RL13
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_q <= SRL_ARM_RST;
      end else begin
         armed_q <= armed_d;
      end
   end

   // ==============================================================
   // Pending requests and SRQ
   // ==============================================================
   // Poll clears; an event in the poll cycle still sets its bit
   assign pend_d = (poll_req ? srl_evt_t'(4'h0) : pend_q) | new_evt;  // RL14

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q   <= '0;
         srq_oe_q <= 1'b0;
      end else begin
         pend_q   <= pend_d;
         srq_oe_q <= any_pend;                                  // RL1
      end
   end

   // Status byte assembly
   always_comb begin
      stb_w                    = 8'h00;
      stb_w[SRL_STB_UNITS_KEY] = pend_q.key;                    // RL10
      stb_w[SRL_STB_SWEEP_END] = pend_q.sweep;
      stb_w[SRL_STB_HW_FAULT]  = pend_q.fault;
      stb_w[SRL_STB_ILLEGAL]   = pend_q.illegal;
      stb_w[SRL_STB_RQS]       = (pend_q != '0);
   end

   // Byte captured at the poll, held for the bus side
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         poll_byte_q <= 8'h00;
      end else if (poll_req) begin
         poll_byte_q <= stb_w;                                  // RL1
      end
   end

   // ==============================================================
   // Keypad value
   // ==============================================================
   // Entry latched on completion; output copy taken on command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         value_q     <= 32'h0000_0000;
         out_value_q <= 32'h0000_0000;
      end else begin
         if (entry_done) begin
            value_q <= keypad_value;                            // RL6
         end
         if (value_cmd) begin
            out_value_q <= value_q;                             // RL7
         end
      end
   end

   // ==============================================================
   // Local interrupt
   // ==============================================================
   assign irq_evt[SRL_IRQ_SRQ_RAISED] = (pend_q == '0) & any_pend;
   assign irq_evt[SRL_IRQ_POLLED]     = poll_req;
   assign irq_evt[SRL_IRQ_VALUE_OUT]  = value_cmd;
   assign irq_evt[SRL_IRQ_ENTRY_DONE] = entry_done;
   // Read clears, but an event in the read cycle is kept
   assign irq_stat_d = (irq_rd ? 4'h0 : irq_stat_q) | irq_evt;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_q <= 4'h0;
         irq_mask_q <= SRL_IRQ_MASK_RST;
      end else begin
         irq_stat_q <= irq_stat_d;
         if (mask_wr) begin
            irq_mask_q <= pwdata[SRL_IRQ_W-1:0];
         end
      end
   end

   // ==============================================================
   // APB slave: zero wait states
   // ==============================================================
   // Unknown offsets answer with an error and zero data
   wire hit = (paddr == SRL_OFF_CMD) | (paddr == SRL_OFF_ARMED)
            | (paddr == SRL_OFF_STATUS) | (paddr == SRL_OFF_VALUE)
            | (paddr == SRL_OFF_IRQ_STAT) | (paddr == SRL_OFF_IRQ_MASK)
            | (paddr == SRL_OFF_POLL_BYTE);

   assign pready  = 1'b1;
   assign pslverr = access & ~hit;
   assign prdata  = !rd_acc                       ? 32'h0000_0000 :
                    (paddr == SRL_OFF_ARMED)      ? {27'h0, srq_s, armed_q} :
                    (paddr == SRL_OFF_STATUS)     ? {24'h0, stb_w} :
                    (paddr == SRL_OFF_VALUE)      ? out_value_q :
                    (paddr == SRL_OFF_IRQ_STAT)   ? {28'h0, irq_stat_q} :
                    (paddr == SRL_OFF_IRQ_MASK)   ? {28'h0, irq_mask_q} :
                    (paddr == SRL_OFF_POLL_BYTE)  ? {24'h0, poll_byte_q} :
                                                    32'h0000_0000;

   // Output drive
   assign srq_o        = 1'b0;
   assign srq_oe       = srq_oe_q;
   assign poll_byte    = poll_byte_q;
   assign active_value = out_value_q;
   assign irq          = |(irq_stat_q & irq_mask_q);

   // ==============================================================
   // Assertions
   // ==============================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_poll_release;
      poll_req && (new_evt == '0) |=> !srq_oe && (pend_q == '0);
   endproperty
   a_poll_release: assert property (p_poll_release) else $error("SRQ held after poll"); // RL1

   property p_sweep_arm;
      cmd_wr && pwdata[SRL_CMD_SWEEP_EN] ##[1:2] sweep_done |=> pend_q.sweep && srq_oe;
   endproperty
   a_sweep_arm: assert property (p_sweep_arm) else $error("Armed sweep end lost"); // RL2

   property p_mask_clear;
      cmd_wr && pwdata[SRL_CMD_MASK_CLR] && !pwdata[SRL_CMD_SWEEP_EN] |=> !armed_q.sweep;
   endproperty
   a_mask_clear: assert property (p_mask_clear) else $error("Sweep still armed"); // RL3

   property p_clear_then_enable;
      cmd_wr && pwdata[SRL_CMD_MASK_CLR] && pwdata[SRL_CMD_KEY_EN]
         && !pwdata[SRL_CMD_FAULT_EN] && !preset_req
         |=> armed_q.key && !armed_q.fault;
   endproperty
   a_clear_then_enable: assert property (p_clear_then_enable) else $error("Enable order wrong"); // RL4

   property p_entry_value;
      key_used |=> pend_q.key && (value_q == $past(keypad_value));
   endproperty
   a_entry_value: assert property (p_entry_value) else $error("Keypad entry not taken"); // RL6

   property p_value_out;
      value_cmd && !entry_done |=> active_value == $past(value_q);
   endproperty
   a_value_out: assert property (p_value_out) else $error("Active value wrong"); // RL7

   property p_remote_ignored;
      svc_edge && !local_s && !key_used && !pend_q.key |=> !pend_q.key;
   endproperty
   a_remote_ignored: assert property (p_remote_ignored) else $error("Service key in remote"); // RL8

   property p_front_panel;
      svc_press |=> pend_q.key && stb_w[SRL_STB_UNITS_KEY] && srq_oe;
   endproperty
   a_front_panel: assert property (p_front_panel) else $error("Service key lost"); // RL9

   property p_poll_byte;
      poll_req && (pend_q != '0) |=> poll_byte[SRL_STB_RQS] && (poll_byte == $past(stb_w));
   endproperty
   a_poll_byte: assert property (p_poll_byte) else $error("Poll byte wrong"); // RL10

   property p_illegal;
      illegal_cmd |=> pend_q.illegal && srq_oe;
   endproperty
   a_illegal: assert property (p_illegal) else $error("Illegal command request lost"); // RL11

   property p_key_cancel;
      key_used && !(cmd_wr && pwdata[SRL_CMD_KEY_EN]) |=> !armed_q.key;
   endproperty
   a_key_cancel: assert property (p_key_cancel) else $error("Key enable not cancelled"); // RL12

   property p_preset;
      preset_req |=> armed_q.fault;
   endproperty
   a_preset: assert property (p_preset) else $error("Preset left fault disarmed"); // RL13

   property p_accumulate;
      !poll_req && (pend_q != '0) |=> srq_oe && ((pend_q & $past(pend_q)) == $past(pend_q));
   endproperty
   a_accumulate: assert property (p_accumulate) else $error("Pending request dropped"); // RL14

   c_poll: cover property (srq_oe ##1 poll_req ##1 !srq_oe);
   c_both: cover property (illegal_cmd && new_evt.sweep);
   c_entry: cover property (key_used ##[1:20] value_cmd);
   c_front: cover property (svc_press);

endmodule : srl_service_request

// ---- tb/srl_ctrl_model.sv ----
`timescale 1ns/100ps
// ==============================================================
// Bus controller model: resolves the request line, serial polls
// ==============================================================
module srl_ctrl_model (
   input  wire logic       pclk,      // Bus clock
   input  wire logic       srq_o,     // Device drive level
   input  wire logic       srq_oe,    // High while device pulls the line
   input  wire logic [7:0] poll_byte, // Byte returned by the poll
   output logic            poll_req,  // Serial poll strobe
   output logic            srq_line   // Resolved line level
);
   // Pull-up keeps the line high unless the device pulls it
   assign srq_line = srq_oe ? srq_o : 1'b1;

   // Idle until a poll is asked for
   initial poll_req = 1'b0;

   // Poll after a delay; a slow controller lets cycles pass first
   task automatic serial_poll(input int dly, output logic [7:0] stb, output logic line_q);
      repeat (dly) @(posedge pclk);
      poll_req <= 1'b1;
      @(posedge pclk);
      poll_req <= 1'b0;
      @(posedge pclk);
      stb    = poll_byte;
      line_q = srq_line;
   endtask : serial_poll
endmodule : srl_ctrl_model

// ---- tb/service_request_logic_tb.sv ----
`timescale 1ns/100ps
// ==============================================================
// Bench top
// ==============================================================
module service_request_logic_tb;
   import srl_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite;   // Clock, reset, bus
   logic [7:0]  paddr, poll_byte;                       // Address, poll byte
   logic [31:0] pwdata, prdata, keypad_value, active_value; // Data paths
   logic        pready, pslverr, preset_req, sweep_done, hw_fault, illegal_cmd;
   logic        units_key_pin, service_key_pin, local_mode_pin, poll_req;
   logic        srq_i, srq_o, srq_oe, irq;              // Line and interrupt
   int          failures, check_count;                  // Verdict counters

   srl_service_request dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .preset_req(preset_req),
      .sweep_done(sweep_done), .hw_fault(hw_fault), .illegal_cmd(illegal_cmd),
      .keypad_value(keypad_value), .units_key_pin(units_key_pin),
      .service_key_pin(service_key_pin), .local_mode_pin(local_mode_pin),
      .poll_req(poll_req), .poll_byte(poll_byte), .active_value(active_value),
      .srq_i(srq_i), .srq_o(srq_o), .srq_oe(srq_oe), .irq(irq));

   srl_ctrl_model ctrl_u (.pclk(pclk), .srq_o(srq_o), .srq_oe(srq_oe),
      .poll_byte(poll_byte), .poll_req(poll_req), .srq_line(srq_i));

   // ==============================================================
   // Shared tasks
   // ==============================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check

   // One APB transfer; holds everything until pready is seen high or 50 edges pass,
   // then one idle edge so the next setup never reassigns psel at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      check({31'h0, pready}, 32'h1, "bus answer");
      r   = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   // Read and compare the bits selected by the mask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      check(r & m, exp, "register read");
   endtask : rd

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   // Poll and expect the byte, then the line let go
   task automatic poll(input int dly, input logic [7:0] exp);
      logic [7:0] b;
      logic       l;
      ctrl_u.serial_poll(dly, b, l);
      check({24'h0, b}, {24'h0, exp}, "poll byte");
      check({31'h0, l}, 32'h1, "line released");
   endtask : poll

   // Event pulses, one cycle wide, several at once allowed
   task automatic events(input logic sw, input logic hf, input logic il);
      sweep_done <= sw; hw_fault <= hf; illegal_cmd <= il;
      @(posedge pclk);
      sweep_done <= 1'b0; hw_fault <= 1'b0; illegal_cmd <= 1'b0;
      tick(2);
   endtask : events

   // Press and release a key pin; held long enough for the synchroniser
   task automatic press(input bit service);
      if (service) service_key_pin <= 1'b1; else units_key_pin <= 1'b1;
      tick(6);
      service_key_pin <= 1'b0; units_key_pin <= 1'b0;
      tick(4);
   endtask : press

   // ==============================================================
   // Scenarios
   // ==============================================================
   task automatic t_reset;
      logic [31:0] r;
      logic        e;
      rd(SRL_OFF_ARMED, 32'h2, 32'hf);
      rd(SRL_OFF_STATUS, 32'h0, 32'hff);
      rd(SRL_OFF_IRQ_MASK, 32'h0, 32'hf);
      apb(1'b0, 8'h1c, 32'h0, r, e);
      check({31'h0, e}, 32'h1, "unmapped read refused");
   endtask : t_reset

   task automatic t_illegal_irq;
      rd(SRL_OFF_IRQ_STAT, 32'h0, 32'hf);
      events(1'b0, 1'b0, 1'b1);
      check({31'h0, srq_i}, 32'h0, "line pulled");
      rd(SRL_OFF_STATUS, 32'h60, 32'hff);
      check({31'h0, irq}, 32'h0, "masked irq");
      wr(SRL_OFF_IRQ_MASK, 32'h1);
      tick(1);
      check({31'h0, irq}, 32'h1, "irq raised");
      rd(SRL_OFF_IRQ_STAT, 32'h1, 32'h1);
      tick(1);
      check({31'h0, irq}, 32'h0, "irq cleared by read");
      poll(0, 8'h60);
      rd(SRL_OFF_STATUS, 32'h0, 32'hff);
   endtask : t_illegal_irq

   task automatic t_sweep;
      events(1'b1, 1'b0, 1'b0);
      rd(SRL_OFF_STATUS, 32'h0, 32'hff);
      wr(SRL_OFF_CMD, 32'h2);
      events(1'b1, 1'b0, 1'b0);
      rd(SRL_OFF_STATUS, 32'h44, 32'hff);
      poll(3, 8'h44);
      wr(SRL_OFF_CMD, 32'h1);
      events(1'b1, 1'b0, 1'b0);
      rd(SRL_OFF_STATUS, 32'h0, 32'hff);
   endtask : t_sweep

   task automatic t_coincident;
      wr(SRL_OFF_CMD, 32'h3);
      rd(SRL_OFF_ARMED, 32'h1, 32'hf);
      wr(SRL_OFF_CMD, 32'h4);
      events(1'b1, 1'b1, 1'b1);
      rd(SRL_OFF_STATUS, 32'h6c, 32'hff);
      tick(5);
      check({31'h0, srq_oe}, 32'h1, "line held until poll");
      poll(0, 8'h6c);
      wr(SRL_OFF_CMD, 32'h1);
      preset_req <= 1'b1;
      tick(1);
      preset_req <= 1'b0;
      rd(SRL_OFF_ARMED, 32'h2, 32'h3);
   endtask : t_coincident

   task automatic t_keypad;
      wr(SRL_OFF_CMD, 32'h19);
      rd(SRL_OFF_ARMED, 32'hc, 32'hf);
      keypad_value <= 32'h1234abcd;
      press(1'b0);
      rd(SRL_OFF_STATUS, 32'h42, 32'hff);
      rd(SRL_OFF_ARMED, 32'h0, 32'hc);
      poll(0, 8'h42);
      wr(SRL_OFF_CMD, 32'h20);
      tick(1);
      check(active_value, 32'h1234abcd, "active value");
      rd(SRL_OFF_VALUE, 32'h1234abcd, 32'hffffffff);
      wr(SRL_OFF_CMD, 32'h10);
      press(1'b0);
      rd(SRL_OFF_STATUS, 32'h0, 32'hff);
      wr(SRL_OFF_CMD, 32'h18);
      press(1'b0);
      rd(SRL_OFF_STATUS, 32'h42, 32'hff);
      poll(1, 8'h42);
      wr(SRL_OFF_CMD, 32'h8);
      poll(0, 8'h00);
      rd(SRL_OFF_ARMED, 32'h0, 32'h4);
   endtask : t_keypad

   task automatic t_service_key;
      press(1'b1);
      rd(SRL_OFF_STATUS, 32'h0, 32'hff);
      local_mode_pin <= 1'b1;
      tick(3);
      press(1'b1);
      rd(SRL_OFF_STATUS, 32'h42, 32'hff);
      poll(2, 8'h42);
   endtask : t_service_key

   // ==============================================================
   // Verdict, clock, watchdog, main sequence
   // ==============================================================
   task automatic give_verdict;
      if (failures == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict

   // 20 MHz clock
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // Whole run is a few hundred cycles; allow ample margin
   initial begin
      #(50 * 5000);
      failures++;
      give_verdict;
   end

   initial begin
      failures = 0; check_count = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
      pwdata = 32'h0; preset_req = 1'b0; sweep_done = 1'b0; hw_fault = 1'b0;
      illegal_cmd = 1'b0; keypad_value = 32'h0; units_key_pin = 1'b0;
      service_key_pin = 1'b0; local_mode_pin = 1'b0;
      tick(6);
      presetn <= 1'b1;
      tick(1);
      t_reset;
      t_illegal_irq;
      t_sweep;
      t_coincident;
      t_keypad;
      t_service_key;
      give_verdict;
   end
endmodule : service_request_logic_tb
